//--- cpu_interrupt_sequencer.sv
// Interrupt acceptance, vectoring and return sequencing for an 8-bit core.
// Assumes the core strobes INSN_DONE at each instruction boundary (after
// any multi-cycle instruction ends) with the op strobes of that
// instruction, stalls while CORE_HOLD is high, and that sources and stack
// memory run on SYS_CLK with a one-cycle stack read.
//
// Functional notes
// - Take only with source and global enable.
// - Default vectors at lowest program addresses.
// - Lowest vector address wins arbitration.
// - Vector select moves table to boot.
// - Boot reset fuse moves reset vector.
// - Boot lock bits block by program counter.
// - Acceptance clears global enable.
// - Re-enabling inside handler allows nesting.
// - Return from handler sets global enable.
// - Vectoring clears the source flag.
// - Writing one clears a flag.
// - Disabled source still sets its flag.
// - Flags held until global enable set.
// - Level sources request only while present.
// - One instruction runs after return.
// - Status register never saved or restored.
// - Disable op blocks same-cycle requests.
// - Instruction after enable runs first.
// - Entry takes four cycles, pushes PC.
// - Multi-cycle instruction finishes before entry.
// - Wake from sleep adds four cycles.
// - Return takes four cycles, pops PC.
// - Global enable is status bit seven.
// - Entry push lowers stack pointer by two.
//
// Chosen here: the APB interface to the registers and the register addresses.
`include "cis_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_interrupt_sequencer
    import cis_pkg::*;
#(
    parameter int NSRC = 8,
    parameter logic [15:0] BOOT_START = 16'h3800
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NSRC-1:0] IRQ_SRC,
    input wire logic INSN_DONE,
    input wire logic OP_SEI,
    input wire logic OP_IRQ_DISABLE,
    input wire logic OP_RETURN,
    input wire logic [15:0] PC_NOW,
    input wire logic PC_IN_BOOT,
    input wire logic SLEEPING,
    input wire logic APP_LOCK_B,
    input wire logic BOOT_LOCK_B,
    input wire logic BOOT_RESET_FUSE,
    input wire logic [7:0] STACK_RDATA,
    output logic CORE_HOLD,
    output logic PC_LOAD,
    output logic [15:0] PC_NEW,
    output logic [15:0] RESET_VECTOR,
    output logic STACK_WE,
    output logic STACK_RE,
    output logic [15:0] STACK_ADDR,
    output logic [7:0] STACK_WDATA,
    output logic GIE,
    output logic IRQ_TAKEN
);

    // Refuse source counts the index fields cannot carry
    generate
        if (NSRC < 1 || NSRC > 16) begin : g_bad_nsrc
            $error("NSRC must lie between 1 and 16");
        end
    endgenerate

    seq_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [NSRC-1:0] en_q, kind_q, flag_q, flag_d, src_q, pend;
    logic [3:0] win_idx, idx_q;
    logic win_any;
    logic vts_q;
    logic gie_q;
    logic [15:0] sp_q, sp_d;
    logic [15:0] ret_pc_q;
    logic [7:0] pop_hi_q;
    logic [7:0] pop_lo_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic hold_q, pc_load_q, taken_q;
    logic [15:0] pc_new_q, rst_vec_q;
    logic swe_q, sre_q;
    logic [15:0] saddr_q;
    logic [7:0] swdata_q;

    // APB decode; one wait state so every answer comes from a flop
    wire acc_first = PSEL & PENABLE & ~pready_q;
    wire acc_last = PSEL & PENABLE & pready_q;
    wire wr_fire = acc_last & PWRITE;
    wire hit_ctrl = (PADDR == `CIS_OFF_CTRL);
    wire hit_en = (PADDR == `CIS_OFF_ENABLE);
    wire hit_flag = (PADDR == `CIS_OFF_FLAG);
    wire hit_kind = (PADDR == `CIS_OFF_KIND);
    wire hit_stat = (PADDR == `CIS_OFF_STATUS);
    wire hit_sp = (PADDR == `CIS_OFF_SP);
    wire hit_any = hit_ctrl | hit_en | hit_flag | hit_kind | hit_stat
        | hit_sp;
    wire [NSRC-1:0] flag_w1c = (wr_fire & hit_flag) ? PWDATA[NSRC-1:0]
        : '0;

    wire lock_block = (APP_LOCK_B & ~PC_IN_BOOT & vts_q)
        | (BOOT_LOCK_B & PC_IN_BOOT & ~vts_q);

    wire [NSRC-1:0] armed = pend & en_q;

    wire take = (state_q == ST_RUN) & INSN_DONE & win_any & gie_q
        & ~OP_IRQ_DISABLE & ~OP_SEI & ~OP_RETURN & ~lock_block;
    wire ret_start = (state_q == ST_RUN) & INSN_DONE & OP_RETURN;

    wire [15:0] vec_base = vts_q ? BOOT_START : `CIS_APP_BASE;
    wire [15:0] vec_num = {12'h000, idx_q} + 16'h0001;
    wire [15:0] vec_addr = 16'(vec_base + 16'(vec_num * `CIS_VEC_STEP));

    wire last_cnt = (cnt_q == 3'(`CIS_ENTRY_CYCLES - 3'd1));
    wire wake_done = (cnt_q == 3'(`CIS_WAKE_EXTRA - 3'd1));
    wire pop_done = (cnt_q == 3'(`CIS_RETURN_CYCLES - 3'd1));
    wire push_end = (state_q == ST_PUSH) & last_cnt;
    wire pop_end = (state_q == ST_POP) & pop_done;

    // Per-source flag and request logic
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            wire fire = kind_q[gi] & IRQ_SRC[gi] & ~src_q[gi];
            wire vec_clr = take & (win_idx == 4'(gi));
            assign flag_d[gi] = fire
                | (flag_q[gi] & ~flag_w1c[gi] & ~vec_clr);
            assign pend[gi] = kind_q[gi] ? flag_q[gi] : IRQ_SRC[gi];
        end
    endgenerate

    always_comb begin
        win_idx = 4'h0;
        win_any = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (armed[i]) begin
                win_idx = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    // Sequence state and counter
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 3'd1;
        case (state_q)
            ST_RUN: begin
                cnt_d = 3'd0;
                if (take) begin
                    state_d = SLEEPING ? ST_WAKE : ST_PUSH;
                end else if (ret_start) begin
                    state_d = ST_POP;
                end
            end
            ST_WAKE: begin
                if (wake_done) begin
                    state_d = ST_PUSH;
                    cnt_d = 3'd0;
                end
            end
            ST_PUSH: begin
                if (last_cnt) begin
                    state_d = ST_RUN;
                end
            end
            ST_POP: begin
                if (pop_done) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
                cnt_d = 3'd0;
            end
        endcase
    end

    // pop raises SP by two
    // Sequencer update beats a software write in the same cycle
    always_comb begin
        sp_d = sp_q;
        if (state_q == ST_PUSH && cnt_q == 3'd2) begin
            sp_d = sp_q - 16'h0002;
        end else if (state_q == ST_POP && cnt_q == 3'd2) begin
            sp_d = sp_q + 16'h0002;
        end else if (wr_fire && hit_sp) begin
            sp_d = PWDATA[15:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q <= ST_RUN;
            cnt_q <= 3'd0;
            sp_q <= `CIS_SP_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sp_q <= sp_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            idx_q <= 4'h0;
            ret_pc_q <= 16'h0000;
        end else if (take) begin
            idx_q <= win_idx;
            ret_pc_q <= PC_NOW;
        end
    end

    // Source flags and their edge history
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            flag_q <= '0;
            src_q <= '0;
        end else begin
            flag_q <= flag_d;
            src_q <= IRQ_SRC;
        end
    end

    // Software-written control
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            en_q <= NSRC'(`CIS_EN_RST);
            kind_q <= NSRC'(`CIS_KIND_RST);
            vts_q <= 1'b0;
        end else if (wr_fire) begin
            if (hit_en) en_q <= PWDATA[NSRC-1:0];
            if (hit_kind) kind_q <= PWDATA[NSRC-1:0];
            if (hit_ctrl) vts_q <= PWDATA[`CIS_CTRL_VTS_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gie_q <= 1'b0;
        end else if (take || (INSN_DONE && OP_IRQ_DISABLE)) begin
            gie_q <= 1'b0;
        end else if (pop_end || (INSN_DONE && OP_SEI)) begin
            gie_q <= 1'b1;
        end else if (wr_fire && hit_ctrl) begin
            gie_q <= PWDATA[`CIS_CTRL_GIE_BIT];
        end
    end

    // Stack traffic: push low then high, pop high then low
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            swe_q <= 1'b0;
            sre_q <= 1'b0;
            saddr_q <= 16'h0000;
            swdata_q <= 8'h00;
        end else begin
            swe_q <= (state_d == ST_PUSH) && (cnt_d < 3'd2);
            sre_q <= (state_d == ST_POP) && (cnt_d < 3'd2);
            saddr_q <= (state_d == ST_PUSH)
                ? 16'(sp_q - {13'h0000, cnt_d})
                : 16'(sp_q + {13'h0000, cnt_d} + 16'h0001);
            // At the take edge ret_pc_q is still stale, so use PC_NOW
            swdata_q <= (cnt_d != 3'd0) ? ret_pc_q[15:8]
                : (take ? PC_NOW[7:0] : ret_pc_q[7:0]);
        end
    end

    // Popped bytes arrive one cycle after each read
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pop_hi_q <= 8'h00;
            pop_lo_q <= 8'h00;
        end else if (state_q == ST_POP) begin
            if (cnt_q == 3'd1) pop_hi_q <= STACK_RDATA;
            if (cnt_q == 3'd2) pop_lo_q <= STACK_RDATA;
        end
    end

    // Core-facing strobes; hold drops in the cycle that loads the PC
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            hold_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_new_q <= 16'h0000;
            taken_q <= 1'b0;
        end else begin
            hold_q <= (state_d != ST_RUN);
            pc_load_q <= push_end | pop_end;
            taken_q <= take;
            if (push_end) pc_new_q <= vec_addr;
            else if (pop_end) pc_new_q <= {pop_hi_q, pop_lo_q};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rst_vec_q <= `CIS_APP_BASE;
        end else begin
            rst_vec_q <= BOOT_RESET_FUSE ? BOOT_START : `CIS_APP_BASE;
        end
    end

    // APB read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[`CIS_CTRL_VTS_BIT] = vts_q;
            rd_mux[`CIS_CTRL_GIE_BIT] = gie_q;
        end else if (hit_en) begin
            rd_mux[NSRC-1:0] = en_q;
        end else if (hit_flag) begin
            rd_mux[NSRC-1:0] = flag_q;
        end else if (hit_kind) begin
            rd_mux[NSRC-1:0] = kind_q;
        end else if (hit_stat) begin
            rd_mux[`CIS_STAT_BUSY_BIT] = (state_q != ST_RUN);
            rd_mux[`CIS_STAT_WAKE_BIT] = (state_q == ST_WAKE);
            rd_mux[`CIS_STAT_POP_BIT] = (state_q == ST_POP);
            rd_mux[`CIS_STAT_IDX_LSB +: 4] = idx_q;
        end else if (hit_sp) begin
            rd_mux[15:0] = sp_q;
        end
    end

    // APB answer: ready in the second access cycle
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc_first;
            pslverr_q <= acc_first & ~hit_any;
            if (acc_first && !PWRITE) prdata_q <= rd_mux;
            else if (acc_last) prdata_q <= 32'h0000_0000;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign CORE_HOLD = hold_q;
    assign PC_LOAD = pc_load_q;
    assign PC_NEW = pc_new_q;
    assign RESET_VECTOR = rst_vec_q;
    assign STACK_WE = swe_q;
    assign STACK_RE = sre_q;
    assign STACK_ADDR = saddr_q;
    assign STACK_WDATA = swdata_q;
    assign GIE = gie_q;
    assign IRQ_TAKEN = taken_q;

endmodule

`default_nettype wire

//--- cis_cfg.svh
// Constants for the CPU interrupt sequencer: register offsets, field
// positions, reset values and sequence cycle counts.
// Assumes inclusion by bare name from the sequencer and its bench.
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// APB byte offsets, one aligned word each
`define CIS_OFF_CTRL 8'h00
`define CIS_OFF_ENABLE 8'h04
`define CIS_OFF_FLAG 8'h08
`define CIS_OFF_KIND 8'h0c
`define CIS_OFF_STATUS 8'h10
`define CIS_OFF_SP 8'h14

// Field positions
`define CIS_CTRL_VTS_BIT 0
`define CIS_CTRL_GIE_BIT 7
`define CIS_STAT_BUSY_BIT 0
`define CIS_STAT_WAKE_BIT 1
`define CIS_STAT_POP_BIT 2
`define CIS_STAT_IDX_LSB 8

// Reset values
`define CIS_SP_RST 16'h0000
`define CIS_EN_RST 16'h0000
`define CIS_KIND_RST 16'hffff
`define CIS_APP_BASE 16'h0000

// Sequence timing in SYS_CLK cycles
`define CIS_ENTRY_CYCLES 3'd4
`define CIS_WAKE_EXTRA 3'd4
`define CIS_RETURN_CYCLES 3'd4

// Program words between adjacent vectors
`define CIS_VEC_STEP 16'h0002

`endif

//--- cis_pkg.sv
// Types used by the CPU interrupt sequencer; its bench does not import them.
// Assumes the constants of cis_cfg.svh are included where needed.
package cis_pkg;

    // Sequencer phases
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAKE,
        ST_PUSH,
        ST_POP
    } seq_state_t;

endpackage

//--- cis_asserts.sv
// Checker for entry, return and gating timing of the sequencer.
// Assumes it is bound to cpu_interrupt_sequencer on one clock.
`timescale 1ns/1ps
`default_nettype none
module cis_asserts (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic INSN_DONE,
    input wire logic OP_SEI,
    input wire logic OP_IRQ_DISABLE,
    input wire logic OP_RETURN,
    input wire logic [15:0] PC_NOW,
    input wire logic SLEEPING,
    input wire logic CORE_HOLD,
    input wire logic PC_LOAD,
    input wire logic STACK_WE,
    input wire logic [7:0] STACK_WDATA,
    input wire logic GIE,
    input wire logic IRQ_TAKEN
);
    // Low return byte, pushed first
    wire logic [7:0] pc_lo = PC_NOW[7:0];

    // Single domain, so one clocking and one reset for every property
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    chk_take_needs_gie: assert property (
        IRQ_TAKEN |-> $past(GIE))
        else $error("take while globally disabled");
    chk_take_clears_gie: assert property (
        IRQ_TAKEN |-> !GIE)
        else $error("global enable kept after take");
    chk_entry_time: assert property (
        IRQ_TAKEN && !$past(SLEEPING) |-> ##4 PC_LOAD)
        else $error("vector load not four cycles after take");
    chk_wake_time: assert property (
        IRQ_TAKEN && $past(SLEEPING) |-> ##8 PC_LOAD)
        else $error("wake entry not four cycles longer");
    chk_push_low: assert property (
        IRQ_TAKEN && !$past(SLEEPING) |-> STACK_WE
        && STACK_WDATA == $past(pc_lo))
        else $error("low return byte not pushed first");
    chk_hold_span: assert property (
        IRQ_TAKEN && !$past(SLEEPING) |-> CORE_HOLD [*4] ##1 !CORE_HOLD)
        else $error("core hold span wrong");
    chk_return_time: assert property (
        INSN_DONE && OP_RETURN && !CORE_HOLD |-> ##5 (PC_LOAD && GIE))
        else $error("return load or enable late");
    chk_disable_block: assert property (
        INSN_DONE && OP_IRQ_DISABLE |=> !IRQ_TAKEN && !GIE)
        else $error("take after disable op");
    chk_next_first: assert property (
        INSN_DONE && (OP_SEI || OP_RETURN) |=> !IRQ_TAKEN)
        else $error("take on enable or return boundary");
endmodule

bind cpu_interrupt_sequencer cis_asserts sequence_checks (
    .SYS_CLK, .RST, .INSN_DONE, .OP_SEI, .OP_IRQ_DISABLE, .OP_RETURN,
    .PC_NOW, .SLEEPING, .CORE_HOLD, .PC_LOAD, .STACK_WE, .STACK_WDATA,
    .GIE, .IRQ_TAKEN);
`default_nettype wire

//--- cis_stack_model.sv
// Byte-wide stack memory standing on the sequencer's stack port.
// Assumes one-cycle read latency on the core clock.
`timescale 1ns/1ps
`default_nettype none
module cis_stack_model (
    input wire logic clk,
    input wire logic we,
    input wire logic re,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;

    // Read data lasts one cycle, then the inverse of the last byte,
    // so a late sample can never match by luck
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        if (re) begin
            rdata <= mem[addr];
            last_q <= mem[addr];
        end else begin
            rdata <= ~last_q;
        end
    end
endmodule
`default_nettype wire

//--- cpu_interrupt_sequencer_bench.sv
// Bench for the interrupt sequencer: APB master, core strobes, sources.
// Assumes the stack model on the stack port; NSRC stays at 8.
`timescale 1ns/1ps
`default_nettype none
`include "cis_cfg.svh"
module cpu_interrupt_sequencer_bench;
    localparam logic [15:0] BS = 16'h3800; // Arbitrary boot start
    logic SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic INSN_DONE, OP_SEI, OP_IRQ_DISABLE, OP_RETURN, PC_IN_BOOT;
    logic SLEEPING, APP_LOCK_B, BOOT_LOCK_B, BOOT_RESET_FUSE, GIE;
    logic CORE_HOLD, PC_LOAD, STACK_WE, STACK_RE, IRQ_TAKEN;
    logic [7:0] PADDR, IRQ_SRC, STACK_RDATA, STACK_WDATA;
    logic [15:0] PC_NOW, PC_NEW, RESET_VECTOR, STACK_ADDR;
    logic [31:0] PWDATA, PRDATA;
    int err_count = 0;
    int checks_done = 0;

    cpu_interrupt_sequencer #(.NSRC(8), .BOOT_START(BS)) uut (
        .SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .IRQ_SRC, .INSN_DONE, .OP_SEI,
        .OP_IRQ_DISABLE, .OP_RETURN, .PC_NOW, .PC_IN_BOOT, .SLEEPING,
        .APP_LOCK_B, .BOOT_LOCK_B, .BOOT_RESET_FUSE, .STACK_RDATA,
        .CORE_HOLD, .PC_LOAD, .PC_NEW, .RESET_VECTOR, .STACK_WE,
        .STACK_RE, .STACK_ADDR, .STACK_WDATA, .GIE, .IRQ_TAKEN);
    cis_stack_model stk (.clk(SYS_CLK), .we(STACK_WE), .re(STACK_RE),
        .addr(STACK_ADDR), .wdata(STACK_WDATA), .rdata(STACK_RDATA));

    // 25 MHz core clock
    initial begin
        SYS_CLK = 1'h0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    // APB transfer; waits for the slave, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic s);
        @(posedge SYS_CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge SYS_CLK);
        end while (PREADY !== 1'h1);
        r = PRDATA;
        s = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic s;
        apb(1'h1, a, d, r, s);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic s;
        apb(1'h0, a, 32'h0, r, s);
        chk(r, e);
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge SYS_CLK);
        IRQ_SRC <= v;
        @(posedge SYS_CLK);
        IRQ_SRC <= 8'h00;
    endtask

    // One instruction boundary, then watch take, load and its cycle
    task automatic run(input logic [2:0] op, input logic tk,
            input logic [15:0] pc, input int cyc);
        logic t;
        logic [15:0] p;
        int n;
        t = 1'h0;
        p = 16'h0;
        n = 0;
        @(posedge SYS_CLK);
        INSN_DONE <= 1'h1;
        {OP_SEI, OP_IRQ_DISABLE, OP_RETURN} <= op;
        @(posedge SYS_CLK);
        INSN_DONE <= 1'h0;
        {OP_SEI, OP_IRQ_DISABLE, OP_RETURN} <= 3'h0;
        for (int i = 1; i <= 12; i++) begin
            @(negedge SYS_CLK);
            if (IRQ_TAKEN === 1'h1) t = 1'h1;
            if (PC_LOAD === 1'h1) begin
                p = PC_NEW;
                n = i;
            end
        end
        chk(t, tk);
        chk(p, pc);
        chk(n, cyc);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic s;
        rd(`CIS_OFF_CTRL, 32'h0);
        rd(`CIS_OFF_KIND, 32'hff);
        apb(1'h0, 8'h18, 32'h0, r, s);
        chk(s, 1'h1);
        chk(RESET_VECTOR, 16'h0);
        BOOT_RESET_FUSE <= 1'h1;
        repeat (3) @(posedge SYS_CLK);
        chk(RESET_VECTOR, BS);
        BOOT_RESET_FUSE <= 1'h0;
    endtask

    task automatic t_flags;
        pulse(8'h08);
        rd(`CIS_OFF_FLAG, 32'h08);
        wr(`CIS_OFF_FLAG, 32'h0);
        rd(`CIS_OFF_FLAG, 32'h08);
        wr(`CIS_OFF_FLAG, 32'h08);
        rd(`CIS_OFF_FLAG, 32'h0);
    endtask

    task automatic t_entry;
        pulse(8'h24);
        wr(`CIS_OFF_ENABLE, 32'h24);
        wr(`CIS_OFF_SP, 32'h0100);
        run(3'h0, 1'h0, 16'h0, 0);
        wr(`CIS_OFF_CTRL, 32'h80);
        run(3'h0, 1'h1, 16'h6, 5);
        chk(stk.mem[16'h0100], 8'h34);
        chk(stk.mem[16'h00ff], 8'h12);
        rd(`CIS_OFF_SP, 32'h00fe);
        rd(`CIS_OFF_FLAG, 32'h20);
        rd(`CIS_OFF_STATUS, 32'h0200);
        chk(GIE, 1'h0);
    endtask

    task automatic t_return;
        run(3'h1, 1'h0, 16'h1234, 5);
        chk(GIE, 1'h1);
        rd(`CIS_OFF_SP, 32'h0100);
        wr(`CIS_OFF_CTRL, 32'h81);
        run(3'h0, 1'h1, BS + 16'hc, 5);
    endtask

    task automatic t_gating;
        pulse(8'h02);
        wr(`CIS_OFF_ENABLE, 32'h26);
        run(3'h0, 1'h0, 16'h0, 0);
        wr(`CIS_OFF_CTRL, 32'h81);
        run(3'h0, 1'h1, BS + 16'h4, 5);
        pulse(8'h02);
        wr(`CIS_OFF_CTRL, 32'h81);
        run(3'h2, 1'h0, 16'h0, 0);
        chk(GIE, 1'h0);
        run(3'h4, 1'h0, 16'h0, 0);
        chk(GIE, 1'h1);
        run(3'h4, 1'h0, 16'h0, 0);
        run(3'h0, 1'h1, BS + 16'h4, 5);
    endtask

    task automatic t_lock;
        pulse(8'h02);
        APP_LOCK_B <= 1'h1;
        wr(`CIS_OFF_CTRL, 32'h81);
        run(3'h0, 1'h0, 16'h0, 0);
        PC_IN_BOOT <= 1'h1;
        run(3'h0, 1'h1, BS + 16'h4, 5);
        APP_LOCK_B <= 1'h0;
        pulse(8'h02);
        BOOT_LOCK_B <= 1'h1;
        wr(`CIS_OFF_CTRL, 32'h80);
        run(3'h0, 1'h0, 16'h0, 0);
        PC_IN_BOOT <= 1'h0;
        run(3'h0, 1'h1, 16'h4, 5);
        BOOT_LOCK_B <= 1'h0;
    endtask

    task automatic t_level_sleep;
        wr(`CIS_OFF_KIND, 32'hfe);
        pulse(8'h01);
        wr(`CIS_OFF_ENABLE, 32'h01);
        wr(`CIS_OFF_CTRL, 32'h80);
        run(3'h0, 1'h0, 16'h0, 0);
        rd(`CIS_OFF_FLAG, 32'h0);
        IRQ_SRC <= 8'h01;
        run(3'h0, 1'h1, 16'h2, 5);
        pulse(8'h02);
        wr(`CIS_OFF_ENABLE, 32'h02);
        wr(`CIS_OFF_CTRL, 32'h80);
        SLEEPING <= 1'h1;
        run(3'h0, 1'h1, 16'h4, 9);
        SLEEPING <= 1'h0;
    endtask

    task automatic results;
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence; strobes stay low outside transfers
    initial begin
        RST = 1'h1;
        {PSEL, PENABLE, PWRITE, INSN_DONE, OP_SEI} = 5'h0;
        {OP_IRQ_DISABLE, OP_RETURN, PC_IN_BOOT, SLEEPING} = 4'h0;
        {APP_LOCK_B, BOOT_LOCK_B, BOOT_RESET_FUSE} = 3'h0;
        {PADDR, IRQ_SRC, PWDATA} = 48'h0;
        PC_NOW = 16'h1234;
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'h0;
        t_reset;
        t_flags;
        t_entry;
        t_return;
        t_gating;
        t_lock;
        t_level_sleep;
        results;
    end

    // Watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        err_count++;
        results;
    end
endmodule
`default_nettype wire
